// ### test_tic_top.sv
// testbench: register, timebase, interrupt and wake scenarios of tic_top
module test_tic_top;
    import tic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // -----------------------------------------------------------
    // signals
    // -----------------------------------------------------------
    logic        mclk_i;
    logic        rst_n_i      = 1'b0;
    logic        xtal_i       = 1'b0;
    logic        powerdown_i  = 1'b0;
    logic [9:0]  address_i    = 10'h000;
    logic        read_i       = 1'b0;
    logic        write_i      = 1'b0;
    logic [31:0] writedata_i  = 32'h00000000;
    logic [3:0]  byteenable_i = 4'h0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        irq_o;
    logic        wake_o;
    logic        ph           = 1'b0;
    logic [31:0] rdv;
    int          n_mismatch   = 0;
    int          cmp_count    = 0;
    int          wcnt;
    logic [7:0]  regs [9]     = '{IDX_CONTROL, IDX_FRACTION, IDX_SECONDS,
        IDX_MINUTES, IDX_HOURS, IDX_TARGET, IDX_IRQ_STAT, IDX_IRQ_MASK,
        IDX_COUNT};

    tic_top tic_top_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .xtal_i(xtal_i),
        .powerdown_i(powerdown_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .irq_o(irq_o), .wake_o(wake_o)
    );

    // core clock, 20 ns period
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // crystal stand-in: period of four core cycles, 1024 cycles per tick
    always @(posedge mclk_i) begin
        ph <= ~ph;
        if (ph) begin
            xtal_i <= ~xtal_i;
        end
    end

    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low; the
    // release edge passes before the next call, spacing accesses
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        address_i <= {idx, 2'b00};
        read_i <= !wr;
        write_i <= wr;
        writedata_i <= {24'h000000, wd};
        byteenable_i <= be;
        do begin
            @(posedge mclk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
        end
        rdv = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd, 4'hF);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00, 4'hF);
        check(rdv, exp);
    endtask

    task automatic wait_irq();
        wcnt = 0;
        while (irq_o !== 1'b1 && wcnt < 8000) begin
            @(posedge mclk_i);
            wcnt++;
        end
        if (wcnt >= 8000) begin
            n_mismatch++;
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog on a hung run
    initial begin
        repeat (40000) @(posedge mclk_i);
        n_mismatch++;
        give_verdict();
    end

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        foreach (regs[i]) rdc(regs[i], 32'h0);
        rdc(8'hB7, 32'h0);
        bus(1'b1, IDX_TARGET, 8'h55, 4'h0);
        rdc(IDX_TARGET, 32'h0);
        wr(IDX_SECONDS, 8'h2A);
        rdc(IDX_SECONDS, 32'h2A);
        // repeating, fraction timebase, target three
        wr(IDX_SECONDS, 8'h00);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_TARGET, 8'h03);
        wr(IDX_CONTROL, 8'h03);
        wait_irq();
        check(32'(wcnt > 2000 && wcnt < 3300), 32'h1);
        check({31'h0, irq_o}, 32'h1);
        rdc(IDX_CONTROL, 32'h07);
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_FRACTION, 32'h3);
        // stop, clear flag and status
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_IRQ_STAT, 8'h01);
        rdc(IDX_IRQ_STAT, 32'h0);
        check({31'h0, irq_o}, 32'h0);
        rdc(IDX_FRACTION, 32'h0);
        // single interval
        wr(IDX_TARGET, 8'h01);
        wr(IDX_CONTROL, 8'h0B);
        wait_irq();
        rdc(IDX_CONTROL, 32'h0D);
        rdc(IDX_COUNT, 32'h0);
        // masked match sets status but not the interrupt
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_IRQ_STAT, 8'h01);
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_CONTROL, 8'h03);
        repeat (2200) @(posedge mclk_i);
        check({31'h0, irq_o}, 32'h0);
        rdc(IDX_IRQ_STAT, 32'h1);
        wr(IDX_IRQ_MASK, 8'h01);
        check({31'h0, irq_o}, 32'h1);
        // other timebases, preloaded just short of rollover
        for (int tb = 1; tb < 4; tb++) begin
            wr(IDX_CONTROL, 8'h00);
            wr(IDX_IRQ_STAT, 8'h01);
            wr(IDX_FRACTION, 8'h7E);
            wr(IDX_SECONDS, (tb > 1) ? 8'h3B : 8'h00);
            wr(IDX_MINUTES, (tb > 2) ? 8'h3B : 8'h00);
            wr(IDX_HOURS, 8'h00);
            powerdown_i <= (tb == 3);
            wr(IDX_CONTROL, {2'b00, 2'(tb), 4'h3});
            wait_irq();
            check({31'h0, wake_o}, {31'h0, tb == 3});
            rdc(IDX_FRACTION, 32'h0);
            rdc(IDX_SECONDS, (tb == 1) ? 32'h1 : 32'h0);
            rdc(IDX_MINUTES, (tb == 2) ? 32'h1 : 32'h0);
            rdc(IDX_HOURS, (tb == 3) ? 32'h1 : 32'h0);
        end
        powerdown_i <= 1'b0;
        wr(IDX_CONTROL, 8'h00);
        rdc(IDX_FRACTION, 32'h7E);
        check({31'h0, wake_o}, 32'h0);
        give_verdict();
    end
endmodule

// ### tic_pkg.sv
// package: offsets, field layout, reset values and timing of the interval counter
package tic_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL  = 8'hA1;
    localparam logic [7:0] IDX_FRACTION = 8'hA2;
    localparam logic [7:0] IDX_SECONDS  = 8'hA3;
    localparam logic [7:0] IDX_MINUTES  = 8'hA4;
    localparam logic [7:0] IDX_HOURS    = 8'hA5;
    localparam logic [7:0] IDX_TARGET   = 8'hA6;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hB0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;
    localparam logic [7:0] IDX_COUNT    = 8'hB2;

    // ------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------
    localparam int          CTL_TIME_CLOCK_ENABLE_BIT  = 0;
    localparam int          CTL_INTERVAL_COUNT_ENABLE_BIT  = 1;
    localparam int          CTL_FLAG_BIT  = 2;
    localparam int          CTL_ONE_BIT   = 3;
    localparam int          CTL_TB_LO_BIT = 4;
    localparam int          CTL_TB_HI_BIT = 5;
    localparam int          CTL_H24_BIT   = 6;
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic [7:0]  TIME_RST      = 8'h00;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // ------------------------------------------------------------
    // counting limits of the time-of-day chain
    // ------------------------------------------------------------
    localparam logic [7:0] FRAC_LIMIT  = 8'h7F;  // 0..127
    localparam logic [7:0] SEC_LIMIT   = 8'h3B;  // 0..59
    localparam logic [7:0] MIN_LIMIT   = 8'h3B;  // 0..59
    localparam logic [7:0] HOUR_LIM24  = 8'h17;  // 0..23
    localparam logic [7:0] HOUR_LIM256 = 8'hFF;  // 0..255

    // ------------------------------------------------------------
    // crystal time base
    // ------------------------------------------------------------
    localparam int         XTAL_HZ        = 32768;
    localparam int         FRAC_PER_SEC   = 128;
    localparam int         EDGES_PER_TICK = XTAL_HZ / FRAC_PER_SEC;
    localparam logic [7:0] EDGE_DIV_LAST  = 8'(EDGES_PER_TICK - 1);

    // ------------------------------------------------------------
    // enums and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TB_FRACTION = 2'h0,
        TB_SECONDS  = 2'h1,
        TB_MINUTES  = 2'h2,
        TB_HOURS    = 2'h3
    } tic_timebase_e;

    typedef struct packed {
        logic          h24;
        tic_timebase_e timebase;
        logic          one_shot_interval;
        logic          interval_match_flag;
        logic          interval_count_enable;
        logic          time_clock_enable;
    } tic_ctrl_s;

    typedef struct packed {
        logic [7:0] fraction_seconds;
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
    } tic_time_s;

endpackage

// ### tic_stage.sv
// module: one wrapping stage of the time-of-day chain
module tic_stage
    import tic_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // counting
    input  wire logic       inc_i,
    input  wire logic [7:0] limit_i,
    // load
    input  wire logic       load_i,
    input  wire logic [7:0] load_val_i,
    // state
    output logic [7:0]      value_o,
    output logic            roll_o
);

    typedef struct packed {
        logic [7:0] value;
    } tic_stg_s;

    tic_stg_s st_r;
    tic_stg_s st_nxt;

    // rollover when incremented at the limit; load takes priority
    assign roll_o = inc_i && !load_i && (st_r.value >= limit_i);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (load_i) begin
            st_nxt.value = load_val_i;          // RL7
        end else if (inc_i) begin
            if (st_r.value >= limit_i) begin
                st_nxt.value = 8'h00;           // RL10
            end else begin
                st_nxt.value = st_r.value + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_o = st_r.value;

endmodule

// ### tic_tick_gen.sv
// module: crystal sampler and divider producing the 1/128 s tick
module tic_tick_gen
    import tic_pkg::*;
(
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // crystal and control
    input  wire logic xtal_i,
    input  wire logic run_i,
    // tick out
    output logic      tick_o
);

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [7:0] div;
        logic       tick;
    } tic_tg_s;

    tic_tg_s st_r;
    tic_tg_s st_nxt;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // sync1 feeds only sync2; edges are judged on sync2 against prev
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = xtal_i;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;
        st_nxt.tick  = 1'b0;
        if (!run_i) begin
            st_nxt.div = 8'h00;                 // RL12
        end else if (st_r.sync2 && !st_r.prev) begin
            // one tick per 256 crystal rising edges
            if (st_r.div == EDGE_DIV_LAST) begin // RL2
                st_nxt.div  = 8'h00;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.div = st_r.div + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;

endmodule

// ### tic_top.sv
// module: time interval counter with Avalon-MM registers and interrupt
// ------------------------------------------------------------
// What this block does
// RL1: timeouts from one 1/128 s tick to 255 hours via timebase and count.
// RL2: counting is paced by the 32.768 kHz crystal, not the core clock.
// RL3: counters keep running while the chip is powered down.
// RL4: interval count advances once per rollover of the selected stage; the code steps it on each advance of that stage.
// RL5: count equal to target sets the match flag and raises interrupt.
// RL6: in power-down an enabled match wakes the core to its vector.
// RL7: software may preload the time registers with the current time.
// RL8: software spaces its accesses to these registers generously.
// RL9: timebase 00 fraction ticks, 01 seconds, 10 minutes, 11 hours.
// RL10: fraction counts 0 to 127 then rolls into seconds.
// RL11: one-shot mode clears count enable at timeout, else keeps counting.
// RL12: clock enable low stops counters, restores last written times.
// RL13: repeating match clears count; flag and accesses are safe.
// ------------------------------------------------------------
module tic_top
    import tic_pkg::*;
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // crystal time base
    input  wire logic        xtal_i,
    // power state of the core
    input  wire logic        powerdown_i,
    // avalon-mm slave
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    // interrupt and wake
    output logic             irq_o,
    output logic             wake_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        tic_ctrl_s   ctrl;
        tic_time_s   saved;
        logic [7:0]  target;
        logic [7:0]  count;
        logic        irq_stat;
        logic        irq_mask;
        logic        waitreq;
        logic [31:0] rdata;
        logic        irq;
        logic        wake;
    } tic_top_s;

    tic_top_s st_r;
    tic_top_s st_nxt;

    // register index of a bus address, or an unused code when misaligned
    function automatic logic [7:0] reg_index(input logic [9:0] a);
        reg_index = (a[1:0] == 2'h0) ? a[9:2] : 8'h00;
    endfunction

    // pack control fields into the control byte
    function automatic logic [7:0] ctrl_byte(input tic_ctrl_s c);
        ctrl_byte = {1'b0, c.h24, c.timebase, c.one_shot_interval,
                     c.interval_match_flag, c.interval_count_enable,
                     c.time_clock_enable};
    endfunction

    // ------------------------------------------------------------
    // tick generation and time-of-day chain
    // ------------------------------------------------------------
    logic       tick;
    logic       run;
    logic       restore;
    logic [3:0] load;
    logic [7:0] load_val;
    logic [7:0] frac_v;
    logic [7:0] sec_v;
    logic [7:0] min_v;
    logic [7:0] hour_v;
    logic       frac_roll;
    logic       sec_roll;
    logic       min_roll;
    logic       hour_roll;
    logic [7:0] hour_lim;
    logic [7:0] idx;
    logic       wr_now;
    logic       sel_roll;

    assign run      = st_r.ctrl.time_clock_enable;
    assign restore  = !run;                        // RL12
    assign idx      = reg_index(address_i);
    assign wr_now   = write_i && !st_r.waitreq && byteenable_i[0];
    assign load_val = restore ? 8'h00 : writedata_i[7:0];
    assign hour_lim = st_r.ctrl.h24 ? HOUR_LIM24 : HOUR_LIM256;

    // stage loads: a software write, or a restore while stopped
    always_comb begin
        load[0] = wr_now && (idx == IDX_FRACTION);
        load[1] = wr_now && (idx == IDX_SECONDS);
        load[2] = wr_now && (idx == IDX_MINUTES);
        load[3] = wr_now && (idx == IDX_HOURS);
        if (restore) begin
            load = 4'hF;                           // RL12
        end
    end

    logic [7:0] frac_ld;
    logic [7:0] sec_ld;
    logic [7:0] min_ld;
    logic [7:0] hour_ld;

    // stopped: hold last written value, or the value being written now
    assign frac_ld = (restore && !(wr_now && idx == IDX_FRACTION)) ?
                     st_r.saved.fraction_seconds : writedata_i[7:0];
    assign sec_ld  = (restore && !(wr_now && idx == IDX_SECONDS)) ?
                     st_r.saved.seconds : writedata_i[7:0];
    assign min_ld  = (restore && !(wr_now && idx == IDX_MINUTES)) ?
                     st_r.saved.minutes : writedata_i[7:0];
    assign hour_ld = (restore && !(wr_now && idx == IDX_HOURS)) ?
                     st_r.saved.hours : load_val | writedata_i[7:0];

    tic_tick_gen u_tick (
        .mclk_i (mclk_i),
        .rst_n_i(rst_n_i),
        .xtal_i (xtal_i),
        .run_i  (run),
        .tick_o (tick)
    );

    tic_stage u_frac (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .inc_i     (tick),
        .limit_i   (FRAC_LIMIT),
        .load_i    (load[0]),
        .load_val_i(frac_ld),
        .value_o   (frac_v),
        .roll_o    (frac_roll)
    );

    tic_stage u_sec (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .inc_i     (frac_roll),
        .limit_i   (SEC_LIMIT),
        .load_i    (load[1]),
        .load_val_i(sec_ld),
        .value_o   (sec_v),
        .roll_o    (sec_roll)
    );

    tic_stage u_min (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .inc_i     (sec_roll),
        .limit_i   (MIN_LIMIT),
        .load_i    (load[2]),
        .load_val_i(min_ld),
        .value_o   (min_v),
        .roll_o    (min_roll)
    );

    tic_stage u_hour (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .inc_i     (min_roll),
        .limit_i   (hour_lim),
        .load_i    (load[3]),
        .load_val_i(hour_ld),
        .value_o   (hour_v),
        .roll_o    (hour_roll)
    );

    // ------------------------------------------------------------
    // interval source selection
    // ------------------------------------------------------------
    // each timebase steps the count on the event that advances that stage
    always_comb begin
        unique case (st_r.ctrl.timebase)           // RL9
            TB_FRACTION: sel_roll = tick;
            TB_SECONDS:  sel_roll = frac_roll;
            TB_MINUTES:  sel_roll = sec_roll;
            TB_HOURS:    sel_roll = min_roll;
        endcase
    end

    // ------------------------------------------------------------
    // next state: interval logic, registers and bus answer
    // ------------------------------------------------------------
    logic       match;
    logic [7:0] cnt_inc;
    logic [7:0] rbyte;

    always_comb begin
        st_nxt  = st_r;
        match   = 1'b0;
        cnt_inc = st_r.count + 8'h01;
        rbyte   = 8'h00;

        // interval counter: runs in power-down as well
        if (!st_r.ctrl.interval_count_enable || !run) begin
            st_nxt.count = 8'h00;
        end else if (sel_roll) begin               // RL4 RL3
            if (cnt_inc == st_r.target) begin      // RL5 RL1
                match        = 1'b1;
                st_nxt.count = 8'h00;              // RL13
            end else begin
                st_nxt.count = cnt_inc;
            end
        end

        // software write takes effect at the edge after the release, where waitrequest rises again
        if (wr_now) begin
            unique case (idx)
                IDX_CONTROL: begin
                    st_nxt.ctrl.time_clock_enable =
                        writedata_i[CTL_TIME_CLOCK_ENABLE_BIT];
                    st_nxt.ctrl.interval_count_enable =
                        writedata_i[CTL_INTERVAL_COUNT_ENABLE_BIT];
                    st_nxt.ctrl.one_shot_interval = writedata_i[CTL_ONE_BIT];
                    st_nxt.ctrl.timebase = tic_timebase_e'(
                        writedata_i[CTL_TB_HI_BIT:CTL_TB_LO_BIT]);
                    st_nxt.ctrl.h24 = writedata_i[CTL_H24_BIT];
                    if (!writedata_i[CTL_FLAG_BIT]) begin
                        st_nxt.ctrl.interval_match_flag = 1'b0;
                    end
                end
                IDX_FRACTION: st_nxt.saved.fraction_seconds =
                                  writedata_i[7:0];      // RL7
                IDX_SECONDS:  st_nxt.saved.seconds = writedata_i[7:0];
                IDX_MINUTES:  st_nxt.saved.minutes = writedata_i[7:0];
                IDX_HOURS:    st_nxt.saved.hours   = writedata_i[7:0];
                IDX_TARGET:   st_nxt.target        = writedata_i[7:0];
                IDX_IRQ_STAT: begin
                    if (writedata_i[0]) begin
                        st_nxt.irq_stat = 1'b0;
                    end
                end
                IDX_IRQ_MASK: st_nxt.irq_mask = writedata_i[0];
                default: ;
            endcase
        end

        // a match sets after any clear, so the set wins
        if (match) begin
            st_nxt.ctrl.interval_match_flag = 1'b1;  // RL5 RL13
            st_nxt.irq_stat                 = 1'b1;
            if (st_r.ctrl.one_shot_interval) begin
                st_nxt.ctrl.interval_count_enable = 1'b0;  // RL11
            end
        end

        // read mux
        unique case (idx)
            IDX_CONTROL:  rbyte = ctrl_byte(st_r.ctrl);
            IDX_FRACTION: rbyte = frac_v;
            IDX_SECONDS:  rbyte = sec_v;
            IDX_MINUTES:  rbyte = min_v;
            IDX_HOURS:    rbyte = hour_v;
            IDX_TARGET:   rbyte = st_r.target;
            IDX_IRQ_STAT: rbyte = {7'h00, st_r.irq_stat};
            IDX_IRQ_MASK: rbyte = {7'h00, st_r.irq_mask};
            IDX_COUNT:    rbyte = st_r.count;
            default:      rbyte = 8'h00;
        endcase

        // one wait state per access; data are latched with the release
        if ((read_i || write_i) && st_r.waitreq) begin   // RL13
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata   = {24'h000000, rbyte};
        end else begin
            st_nxt.waitreq = 1'b1;
        end

        // level interrupt and power-down wake
        st_nxt.irq  = st_nxt.irq_stat && st_nxt.irq_mask;           // RL5
        st_nxt.wake = powerdown_i && st_nxt.irq_stat
                      && st_nxt.irq_mask;                            // RL6
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r         <= '0;
            st_r.ctrl    <= tic_ctrl_s'(7'(CONTROL_RST));
            st_r.waitreq <= 1'b1;
            st_r.rdata   <= RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign readdata_o    = st_r.rdata;
    assign waitrequest_o = st_r.waitreq;
    assign irq_o         = st_r.irq;
    assign wake_o        = st_r.wake;

endmodule

// ### tic_top_props.sv
// checker: bus handshake, read data and interrupt relations of tic_top
module tic_top_props
    import tic_pkg::*;
(
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    // core power state
    input wire logic        powerdown_i,
    // avalon-mm slave
    input wire logic [9:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0]  byteenable_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    // interrupt and wake
    input wire logic        irq_o,
    input wire logic        wake_o
);
    // -----------------------------------------------------------
    // one clock domain
    // -----------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // -----------------------------------------------------------
    // bus handshake and read data
    // -----------------------------------------------------------
    chk_wait_take: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("request not answered after one wait state");
    chk_wait_pulse: assert property (
        !waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    chk_wait_idle: assert property (
        !read_i && !write_i && waitrequest_o |=> waitrequest_o)
        else $error("waitrequest dropped with no request");
    chk_rdata_hold: assert property (
        !$fell(waitrequest_o) |-> $stable(readdata_o))
        else $error("read data changed outside an access");
    chk_rdata_upper: assert property (
        readdata_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_unmapped_zero: assert property (
        read_i && !waitrequest_o && address_i[9:2] > IDX_COUNT
        |-> readdata_o == 32'h00000000)
        else $error("unmapped read returned nonzero data");

    // -----------------------------------------------------------
    // interrupt and wake
    // -----------------------------------------------------------
    chk_mask_off: assert property (
        write_i && !waitrequest_o && byteenable_i[0] && !writedata_i[0]
        && address_i[9:2] == IDX_IRQ_MASK |=> !irq_o)
        else $error("interrupt stayed high after masking");
    chk_wake_irq: assert property (
        wake_o |-> irq_o)
        else $error("wake without pending interrupt");
    chk_wake_pd: assert property (
        !powerdown_i |=> !wake_o)
        else $error("wake raised outside power-down");
endmodule

bind tic_top tic_top_props tic_top_props_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .powerdown_i(powerdown_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .irq_o(irq_o), .wake_o(wake_o)
);
